// ---- hdl/irq_seq_map.vh ----
// Purpose: Constants for the interrupt entry and return sequencer.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes: Offsets are byte addresses.
//
// Summary of operation
// - Core runs straight from the chip clock, no internal division.
// - Next fetch overlaps current execution, about one instruction per clock.
// - Two-register ALU result and its flags are written back in one cycle.
// - A request is taken only with its own enable and global enable set.
// - Lowest vector address wins; reset first, external request zero next.
// - Accepting any interrupt clears the global enable.
// - Software setting global enable in a handler allows nesting.
// - Return from handler sets the global enable.
// - Vectoring to a flag-type request clears its flag.
// - Writing one to a flag bit clears it; zero leaves it.
// - Flag requests arriving while disabled stay pending until served or cleared.
// - Level requests trigger only while their condition is present.
// - After return, one main-program instruction runs before another interrupt.
// - Status flags are never saved or restored by entry or return.
// - Clear-global-enable acts at once, even against a same-cycle request.
// - After set-global-enable, the next instruction runs before any interrupt.
// - Entry takes four cycles, pushes the program counter, then vectors.
// - The jump at the vector takes three cycles to reach the handler.
// - A request during a multi-cycle instruction waits for it to finish.
// - Waking from sleep adds four cycles to the entry response.
// - Return takes three cycles: pop two bytes, pointer up two, enable set.
// - Global enable is bit 7 of the status flags register.
// - Pushing the return address decrements the stack pointer by two.
`ifndef IRQ_SEQ_MAP_VH
`define IRQ_SEQ_MAP_VH

`define OFS_STATUS_FLAGS 12'h000
`define OFS_SRC_ENABLE 12'h004
`define OFS_SRC_FLAGS 12'h008
`define OFS_SRC_LEVEL 12'h00C
`define OFS_STACK_PTR 12'h010
`define OFS_SEQ_STATE 12'h014

`define GIE_BIT 7
`define NUM_SRC 8
`define SP_RESET 16'h00FF
`define VEC_STRIDE 16'h0001

`define ENTRY_CYC 3'h4
`define WAKE_CYC 3'h4
`define RET_CYC 3'h4
`define JUMP_CYC 3'h3

`define KIND_OTHER 2'h0
`define KIND_SET_GIE 2'h1
`define KIND_CLR_GIE 2'h2
`define KIND_RETURN 2'h3

`endif

// ---- hdl/irq_sequencer.v ----
// Purpose: Interrupt acceptance, entry and return sequencing for a small 8-bit core.
// Assumes: Sources and instruction sequencer run on pclk; stack RAM reads back one cycle late.
// Notes: Sequencer stalls while hold is high and reloads its PC on pc_load.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "irq_seq_map.vh"

module irq_sequencer (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] src_req,
  input wire instr_done,
  input wire [1:0] instr_kind,
  input wire [15:0] pc_next,
  input wire sleeping,
  input wire alu_flags_we,
  input wire [6:0] alu_flags,
  input wire [7:0] stack_rdata,
  output reg hold,
  output reg pc_load,
  output reg [15:0] pc_target,
  output reg stack_we,
  output reg stack_re,
  output reg [15:0] stack_addr,
  output reg [7:0] stack_wdata,
  output reg [7:0] status_flags_register,
  output reg in_vector_jump
);

  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_WAKE = 5'b00010;
  localparam [4:0] S_ENTRY = 5'b00100;
  localparam [4:0] S_JUMP = 5'b01000;
  localparam [4:0] S_RET = 5'b10000;

  reg [4:0] st_q;
  reg [2:0] cnt_q;
  reg [7:0] en_q;
  reg [7:0] flag_q;
  reg [7:0] level_q;
  reg [15:0] sp_q;
  reg [15:0] ret_pc_q;
  reg [2:0] vec_q;
  reg [7:0] pop_hi_q;
  reg block_q;

  // Lowest index has the lowest vector address, hence top priority
  function [2:0] first_set;
    input [7:0] v;
    integer i;
    begin
      first_set = 3'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        if (v[i]) begin
          first_set = i[2:0];
        end
      end
    end
  endfunction

  // Vector 0 belongs to reset, so sources start one slot higher
  function [15:0] vector_of;
    input [2:0] idx;
    begin
      vector_of = ({13'h0000, idx} + 16'h0001) * `VEC_STRIDE;
    end
  endfunction

  // One-word register hit; every register write decode shares it, the read mux decodes paddr itself
  function wr_hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      wr_hit = (addr == ofs);
    end
  endfunction

  wire apb_wr = psel & penable & pready & pwrite;
  wire wr_status = apb_wr && wr_hit(paddr, `OFS_STATUS_FLAGS);
  wire wr_enable = apb_wr && wr_hit(paddr, `OFS_SRC_ENABLE);
  wire wr_flags = apb_wr && wr_hit(paddr, `OFS_SRC_FLAGS);
  wire wr_level = apb_wr && wr_hit(paddr, `OFS_SRC_LEVEL);
  wire wr_sp = apb_wr && wr_hit(paddr, `OFS_STACK_PTR);
  // Sequence points shared by the output blocks below
  wire ent_push_hi = (st_q == S_ENTRY) && (cnt_q == 3'h2);
  wire ent_done = (st_q == S_ENTRY) && (cnt_q == 3'h0);
  wire jump_done = (st_q == S_JUMP) && (cnt_q == 3'h0);
  wire ret_done = (st_q == S_RET) && (cnt_q == 3'h1);
  wire [7:0] pend = (flag_q | (src_req & level_q)) & en_q;
  wire gie = status_flags_register[`GIE_BIT];
  wire boundary = instr_done | sleeping;
  wire is_cli = instr_done && (instr_kind == `KIND_CLR_GIE);
  wire is_sei = instr_done && (instr_kind == `KIND_SET_GIE);
  wire is_ret = instr_done && (instr_kind == `KIND_RETURN);
  wire [2:0] win = first_set(pend);
  // Only at an instruction boundary, never on clear-enable, return or set-enable
  wire accept = (st_q == S_IDLE) && gie && (|pend) && boundary && !block_q
                && !is_cli && !is_ret && !is_sei;
  wire [7:0] win_hot = 8'h01 << win;
  wire [7:0] clr_hw = accept ? (win_hot & ~level_q) : 8'h00;
  wire [7:0] clr_sw = wr_flags ? pwdata[7:0] : 8'h00;
  // Set wins over either clear so a same-cycle event is not lost
  wire [7:0] flag_d = (flag_q & ~clr_hw & ~clr_sw) | (src_req & ~level_q);
  wire [15:0] sp_dec2 = sp_q - 16'h0002;
  wire [15:0] sp_inc1 = sp_q + 16'h0001;
  wire [15:0] sp_inc2 = sp_q + 16'h0002;

  reg [31:0] rd_mux;
  reg rd_ok;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (paddr)
      `OFS_STATUS_FLAGS: rd_mux = {24'h000000, status_flags_register};
      `OFS_SRC_ENABLE: rd_mux = {24'h000000, en_q};
      `OFS_SRC_FLAGS: rd_mux = {24'h000000, flag_q};
      `OFS_SRC_LEVEL: rd_mux = {24'h000000, level_q};
      `OFS_STACK_PTR: rd_mux = {16'h0000, sp_q};
      `OFS_SEQ_STATE: rd_mux = {16'h0000, block_q, vec_q, cnt_q, st_q, 3'h0, hold};
      default: rd_ok = 1'b0;
    endcase
  end

  // Single undivided clock: every flop here runs on pclk itself
  // Zero wait states: the answer always stands in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_ok;
      if (psel && !penable) begin
        prdata <= rd_mux;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 8'h00;
    end else begin
      flag_q <= flag_d;
    end
  end

  // A new enable only counts from the next instruction boundary
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 8'h00;
    end else begin
      if (wr_enable) begin
        en_q <= pwdata[7:0];
      end
    end
  end

  // Level-type sources never latch, so a vanished condition is simply lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 8'h00;
    end else begin
      if (wr_level) begin
        level_q <= pwdata[7:0];
      end
    end
  end

  // Later assignments win: bus write over instruction effects, entry and return last
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_flags_register <= 8'h00;
    end else begin
      // Flags come straight from the ALU in the cycle of the operation
      if (alu_flags_we) begin
        status_flags_register[6:0] <= alu_flags;
      end
      if (is_sei) begin
        status_flags_register[`GIE_BIT] <= 1'b1;
      end
      if (is_cli) begin
        status_flags_register[`GIE_BIT] <= 1'b0;
      end
      if (wr_status) begin
        status_flags_register <= pwdata[7:0];
      end
      if (accept) begin
        status_flags_register[`GIE_BIT] <= 1'b0;
      end else if (ret_done) begin
        status_flags_register[`GIE_BIT] <= 1'b1;
      end
    end
  end

  // Software may only move the pointer while no push or pop is under way
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_q <= `SP_RESET;
    end else if (wr_sp && st_q == S_IDLE) begin
      sp_q <= pwdata[15:0];
    end else if (ent_push_hi) begin
      sp_q <= sp_dec2;
    end else if (ret_done) begin
      sp_q <= sp_inc2;
    end
  end

  // Hold-off lasts through one completed instruction; the set wins a tie
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_q <= 1'b0;
    end else if (is_sei || ret_done) begin
      block_q <= 1'b1;
    end else if (instr_done) begin
      block_q <= 1'b0;
    end
  end

  // Stall from the accept or return edge until the edge that loads the new PC
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold <= 1'b0;
    end else if (ent_done || ret_done) begin
      hold <= 1'b0;
    end else if (accept || (st_q == S_IDLE && is_ret)) begin
      hold <= 1'b1;
    end
  end

  // Tracks the vector jump for the sequencer's benefit only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_vector_jump <= 1'b0;
    end else if (ent_done) begin
      in_vector_jump <= 1'b1;
    end else if (jump_done) begin
      in_vector_jump <= 1'b0;
    end
  end

  // Sequence counter and stack strobes; shared outputs live in the blocks above
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
      cnt_q <= 3'h0;
      ret_pc_q <= 16'h0000;
      vec_q <= 3'h0;
      pop_hi_q <= 8'h00;
      pc_load <= 1'b0;
      pc_target <= 16'h0000;
      stack_we <= 1'b0;
      stack_re <= 1'b0;
      stack_addr <= 16'h0000;
      stack_wdata <= 8'h00;
    end else begin
      pc_load <= 1'b0;
      stack_we <= 1'b0;
      stack_re <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (accept) begin
            vec_q <= win;
            // Decision is made in the finishing cycle, so no fetch slot is lost
            ret_pc_q <= pc_next;
            if (sleeping && !instr_done) begin
              st_q <= S_WAKE;
              cnt_q <= `WAKE_CYC - 3'h1;
            end else begin
              st_q <= S_ENTRY;
              cnt_q <= `ENTRY_CYC - 3'h1;
            end
          end else if (is_ret) begin
            st_q <= S_RET;
            cnt_q <= `RET_CYC - 3'h1;
            stack_re <= 1'b1;
            stack_addr <= sp_inc1;
          end
        end
        S_WAKE: begin
          if (cnt_q == 3'h0) begin
            st_q <= S_ENTRY;
            cnt_q <= `ENTRY_CYC - 3'h1;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        S_ENTRY: begin
          cnt_q <= cnt_q - 3'h1;
          // Status flags are deliberately not pushed on entry; only bit 7 was cleared at accept
          if (cnt_q == 3'h3) begin
            stack_we <= 1'b1;
            stack_addr <= sp_q;
            stack_wdata <= ret_pc_q[7:0];
          end else if (cnt_q == 3'h2) begin
            stack_we <= 1'b1;
            stack_addr <= sp_q - 16'h0001;
            stack_wdata <= ret_pc_q[15:8];
          end else if (cnt_q == 3'h0) begin
            pc_load <= 1'b1;
            pc_target <= vector_of(vec_q);
            st_q <= S_JUMP;
            cnt_q <= `JUMP_CYC - 3'h1;
          end
        end
        S_JUMP: begin
          // Sequencer runs the vector jump; this only tracks its length
          if (cnt_q == 3'h0) begin
            st_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        S_RET: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h3) begin
            stack_re <= 1'b1;
            stack_addr <= sp_inc2;
          end else if (cnt_q == 3'h2) begin
            pop_hi_q <= stack_rdata;
          end else if (cnt_q == 3'h1) begin
            pc_target <= {pop_hi_q, stack_rdata};
            pc_load <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- tb/stack_ram.sv ----
// Purpose: Stack RAM on the far side of the sequencer
// Assumes: Read data is valid the cycle after a read strobe
// Notes: Idle read data toggles so a stale byte never looks good
`timescale 1ns/1ps
`default_nettype none
module stack_ram (
  input wire logic pclk,
  input wire logic stack_we,
  input wire logic stack_re,
  input wire logic [15:0] stack_addr,
  input wire logic [7:0] stack_wdata,
  output logic [7:0] stack_rdata
);
  logic [7:0] mem [0:255];
  initial stack_rdata = 8'h5A;
  always @(posedge pclk) begin
    if (stack_we)
      mem[stack_addr[7:0]] <= stack_wdata;
    stack_rdata <= stack_re ? mem[stack_addr[7:0]] : ~stack_rdata;
  end
endmodule
`default_nettype wire

// ---- tb/irq_checks_asserts.sv ----
// Purpose: Port timing checks on the sequencer
// Assumes: One clock, async active-low reset
// Notes: Wake-from-sleep timing is left unchecked
`timescale 1ns/1ps
`default_nettype none
module irq_checks (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleeping,
  input wire logic hold,
  input wire logic pc_load,
  input wire logic stack_we,
  input wire logic stack_re,
  input wire logic [15:0] stack_addr,
  input wire logic [7:0] status_flags_register,
  input wire logic in_vector_jump
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("pready missing");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  entry_time_a: assert property ($rose(hold) && !sleeping && !stack_re |->
    ##3 !pc_load ##1 pc_load) else $error("pc load timing");
  push_order_a: assert property ($rose(stack_we) |=>
    stack_we && stack_addr == $past(stack_addr) - 16'h0001) else $error("push order");
  entry_gie_a: assert property ($rose(stack_we) |-> !status_flags_register[7])
    else $error("enable kept");
  ret_gie_a: assert property ($rose(stack_re) |->
    ##3 pc_load ##1 status_flags_register[7]) else $error("return timing");
  jump_len_a: assert property ($rose(in_vector_jump) |->
    in_vector_jump[*3] ##1 !in_vector_jump) else $error("jump length");
  hold_end_a: assert property ($fell(hold) |-> pc_load)
    else $error("hold end");
  load_once_a: assert property (pc_load |=> !pc_load) else $error("pc load twice");
  cover property ($rose(stack_we));
  cover property ($rose(stack_re));
  cover property (pslverr);
endmodule
bind irq_sequencer irq_checks chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .sleeping, .hold, .pc_load, .stack_we, .stack_re, .stack_addr, .status_flags_register,
  .in_vector_jump);
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the interrupt sequencer
// Assumes: Stack RAM model on the far side, core never asleep
// Notes: Expected vectors follow index plus one
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0, penable = 0, pwrite = 0, instr_done = 0, sleeping = 0, alu_flags_we = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [7:0] src_req = 0;
  logic [1:0] instr_kind = 0;
  logic [15:0] pc_next = 0;
  logic [6:0] alu_flags = 0;
  wire [31:0] prdata;
  wire pready, pslverr, hold, pc_load, stack_we, stack_re, in_vector_jump;
  wire [15:0] pc_target, stack_addr;
  wire [7:0] stack_wdata, stack_rdata, status_flags_register;
  logic [31:0] r;
  logic e;
  int c;
  int fails = 0;
  int num_checks = 0;
  always #12.5 pclk = ~pclk;
  irq_sequencer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .src_req, .instr_done, .instr_kind, .pc_next, .sleeping,
    .alu_flags_we, .alu_flags, .stack_rdata, .hold, .pc_load, .pc_target, .stack_we,
    .stack_re, .stack_addr, .stack_wdata, .status_flags_register, .in_vector_jump);
  stack_ram ram (.pclk, .stack_we, .stack_re, .stack_addr, .stack_wdata, .stack_rdata);
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Ends in the first cycle after the accept edge, where hold is settled
  task automatic ins(input logic [1:0] k, input logic [15:0] pc);
    @(posedge pclk);
    instr_done <= 1;
    instr_kind <= k;
    pc_next <= pc;
    @(posedge pclk);
    instr_done <= 0;
    @(negedge pclk);
  endtask
  task automatic wait_load;
    c = 1;
    while (pc_load !== 1'b1 && c < 20) begin
      @(negedge pclk);
      c++;
    end
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge pclk);
    src_req <= m;
    @(posedge pclk);
    src_req <= 0;
  endtask
  task automatic t_entry;
    apb(0, 12'h010, 0);
    chk("sp reset", 32'h00FF, r);
    apb(1, 12'h018, 1);
    chk("unmapped", 1, e);
    apb(1, 12'h010, 32'h80);
    apb(1, 12'h004, 32'h02);
    pulse(8'h02);
    ins(0, 16'h0100);
    chk("gated", 0, hold);
    apb(0, 12'h008, 0);
    chk("flag kept", 32'h02, r);
    apb(1, 12'h008, 32'h02);
    apb(0, 12'h008, 0);
    chk("flag w1c", 0, r);
    pulse(8'h02);
    apb(1, 12'h000, 32'h80);
    ins(0, 16'h1234);
    wait_load;
    chk("entry cycles", 5, c);
    chk("vector", 2, pc_target);
    chk("push lo", 8'h34, ram.mem[8'h80]);
    chk("push hi", 8'h12, ram.mem[8'h7F]);
    apb(0, 12'h010, 0);
    chk("sp push", 32'h7E, r);
    apb(0, 12'h008, 0);
    chk("hw clear", 0, r);
    apb(0, 12'h000, 0);
    chk("gie off", 0, r[7]);
  endtask
  task automatic t_return;
    apb(1, 12'h004, 32'h05);
    pulse(8'h05);
    @(posedge pclk);
    alu_flags_we <= 1;
    alu_flags <= 7'h2A;
    @(posedge pclk);
    alu_flags_we <= 0;
    ins(3, 0);
    wait_load;
    chk("ret cycles", 4, c);
    chk("ret pc", 16'h1234, pc_target);
    apb(0, 12'h010, 0);
    chk("sp pop", 32'h80, r);
    apb(0, 12'h000, 0);
    chk("status", 32'hAA, r);
    ins(0, 16'h1235);
    chk("one more", 0, hold);
    ins(0, 16'h1236);
    wait_load;
    chk("priority", 1, pc_target);
  endtask
  task automatic t_cli_sei;
    apb(1, 12'h000, 32'h80);
    ins(2, 16'h0200);
    chk("cli", 0, hold);
    ins(1, 16'h0201);
    chk("sei", 0, hold);
    ins(0, 16'h0202);
    chk("after sei", 0, hold);
    ins(0, 16'h0203);
    wait_load;
    chk("nested", 3, pc_target);
  endtask
  task automatic t_level;
    apb(1, 12'h00C, 32'h08);
    apb(1, 12'h004, 0);
    pulse(8'h08);
    apb(1, 12'h004, 32'h08);
    apb(1, 12'h000, 32'h80);
    ins(0, 16'h0300);
    chk("level gone", 0, hold);
    @(posedge pclk);
    src_req <= 8'h08;
    ins(0, 16'h0301);
    wait_load;
    chk("level taken", 4, pc_target);
  endtask
  task automatic close_out;
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    t_entry;
    t_return;
    t_cli_sei;
    t_level;
    close_out;
  end
  // Whole run is well under 1000 cycles
  initial begin
    #100us;
    fails++;
    close_out;
  end
endmodule
`default_nettype wire
